//--- qbp_pkg.sv
package qbp_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          PORT_W        = 8;
    localparam logic [7:0]  LATCH_RST     = 8'hFF;
    localparam logic [1:0]  SYNC_RST      = 2'h3;

    // ------------------------------------------------------------
    // strong pull-up pulse after a 0-to-1 change of the driven value
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          BOOST_NS      = 8;
    localparam int          BOOST_CYC     = (BOOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  BOOST_LOAD    = 3'(BOOST_CYC);

    // ------------------------------------------------------------
    // multi-function port bit positions
    // ------------------------------------------------------------
    localparam int          MF_RXD  = 0;
    localparam int          MF_TXD  = 1;
    localparam int          MF_IRQ0 = 2;
    localparam int          MF_IRQ1 = 3;
    localparam int          MF_TMR0 = 4;
    localparam int          MF_TMR1 = 5;
    localparam int          MF_WR   = 6;
    localparam int          MF_RD   = 7;

    // drive controls for one 8-bit port
    typedef struct packed {
        logic [7:0] strong_low_oe_n;
        logic [7:0] strong_high_oe_n;
        logic [7:0] weak_high_en;
    } qbp_drive_s;

    // alternate functions fed into the multi-function port
    typedef struct packed {
        logic txd_en;
        logic txd;
        logic wr_en;
        logic wr_n;
        logic rd_en;
        logic rd_n;
    } qbp_alt_s;

endpackage : qbp_pkg

//--- qbp_pin.sv
`timescale 1ns/100ps
// one quasi-bidirectional pin: latch, boost timer, input synchroniser
module qbp_pin
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic wr_en,
    input  wire logic wr_val,
    input  wire logic ovr_en,
    input  wire logic ovr_val,
    input  wire logic pin_in,
    output logic      latch_q,
    output logic      pin_level,
    output logic      drv_low,
    output logic      drv_high,
    output logic      weak_high
);
    logic       latch_ff;
    logic       nxt_latch;
    logic [2:0] boost_ff;
    logic [2:0] nxt_boost;
    logic [1:0] sync_ff;
    logic [1:0] nxt_sync;
    logic       eff_ff;
    logic       nxt_eff;
    logic       eff_val;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_latch = wr_en ? wr_val : latch_ff;
        eff_val   = ovr_en ? ovr_val : nxt_latch;
        nxt_eff   = eff_val;
        nxt_sync  = {sync_ff[0], pin_in};
        // boost only on a rising 0-to-1 of the driven value; a zero cuts it
        // short so the strong pull-up never fights the pull-down
        if (!eff_val)
            nxt_boost = 3'h0;
        else if (!eff_ff)
            nxt_boost = qbp_pkg::BOOST_LOAD;
        else if (boost_ff != 3'h0)
            nxt_boost = boost_ff - 3'h1;
        else
            nxt_boost = boost_ff;
    end

    // ------------------------------------------------------------
    // registers; reset leaves the pin high and weak
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_ff <= qbp_pkg::LATCH_RST[0];
            eff_ff   <= qbp_pkg::LATCH_RST[0];
            boost_ff <= 3'h0;
            sync_ff  <= qbp_pkg::SYNC_RST;
        end
        else if (ce)
        begin
            latch_ff <= nxt_latch;
            eff_ff   <= nxt_eff;
            boost_ff <= nxt_boost;
            sync_ff  <= nxt_sync;
        end
    end

    // outputs; low drive is held while the driven value is zero
    assign latch_q   = latch_ff;
    assign pin_level = sync_ff[1];
    assign drv_low   = !eff_ff;
    assign drv_high  = (boost_ff != 3'h0);
    assign weak_high = eff_ff;

endmodule : qbp_pin

//--- qbp_port.sv
`timescale 1ns/100ps
module qbp_port
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // upper-address port
    input  wire logic       ua_wr,
    input  wire logic [7:0] ua_wdata,
    output logic [7:0]      ua_latch,
    output logic [7:0]      ua_rdata,
    input  wire logic       ext_bus_active,
    input  wire logic [7:0] ext_addr_hi,
    input  wire logic [7:0] upper_address_port_in,
    output qbp_pkg::qbp_drive_s upper_address_port_drv,
    // multi-function port
    input  wire logic       mf_wr,
    input  wire logic [7:0] mf_wdata,
    output logic [7:0]      mf_latch,
    output logic [7:0]      mf_rdata,
    input  qbp_pkg::qbp_alt_s mf_alt,
    input  wire logic [7:0] multi_function_port_in,
    output qbp_pkg::qbp_drive_s multi_function_port_drv,
    // alternate inputs seen by the core
    output logic            serial_zero_receive,
    output logic            ext_irq_zero_input,
    output logic            ext_irq_one_input,
    output logic            timer_zero_count_input,
    output logic            timer_one_count_input,
    // program memory source
    input  wire logic       external_access_select,
    input  wire logic       int_code_sel,
    output logic            fetch_external
);
    logic [7:0] ua_low;
    logic [7:0] ua_high;
    logic [7:0] ua_weak;
    logic [7:0] mf_low;
    logic [7:0] mf_high;
    logic [7:0] mf_weak;
    logic [7:0] mf_ovr_en;
    logic [7:0] mf_ovr_val;
    logic [1:0] access_sync_ff;
    logic [1:0] nxt_access_sync;

    // ------------------------------------------------------------
    // alternate output overrides on the multi-function port
    // ------------------------------------------------------------
    always_comb
    begin
        mf_ovr_en  = 8'h00;
        mf_ovr_val = 8'hFF;
        mf_ovr_en[qbp_pkg::MF_TXD]  = mf_alt.txd_en;
        mf_ovr_val[qbp_pkg::MF_TXD] = mf_alt.txd;
        mf_ovr_en[qbp_pkg::MF_WR]   = mf_alt.wr_en;
        mf_ovr_val[qbp_pkg::MF_WR]  = mf_alt.wr_n;
        mf_ovr_en[qbp_pkg::MF_RD]   = mf_alt.rd_en;
        mf_ovr_val[qbp_pkg::MF_RD]  = mf_alt.rd_n;
    end

    // ------------------------------------------------------------
    // pin instances; the bus takes the upper port whole
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < qbp_pkg::PORT_W; g++)
        begin : g_pin
            qbp_pin u_ua
            (
                .clk       (clk),
                .resetn    (resetn),
                .ce        (ce),
                .wr_en     (ua_wr),
                .wr_val    (ua_wdata[g]),
                .ovr_en    (ext_bus_active),
                .ovr_val   (ext_addr_hi[g]),
                .pin_in    (upper_address_port_in[g]),
                .latch_q   (ua_latch[g]),
                .pin_level (ua_rdata[g]),
                .drv_low   (ua_low[g]),
                .drv_high  (ua_high[g]),
                .weak_high (ua_weak[g])
            );
            qbp_pin u_mf
            (
                .clk       (clk),
                .resetn    (resetn),
                .ce        (ce),
                .wr_en     (mf_wr),
                .wr_val    (mf_wdata[g]),
                .ovr_en    (mf_ovr_en[g]),
                .ovr_val   (mf_ovr_val[g]),
                .pin_in    (multi_function_port_in[g]),
                .latch_q   (mf_latch[g]),
                .pin_level (mf_rdata[g]),
                .drv_low   (mf_low[g]),
                .drv_high  (mf_high[g]),
                .weak_high (mf_weak[g])
            );
        end
    endgenerate

    // strong output enables are low while driving; weak_high_en is high while the weak pull-up is on
    assign upper_address_port_drv.strong_low_oe_n   = ~ua_low;
    assign upper_address_port_drv.strong_high_oe_n  = ~ua_high;
    assign upper_address_port_drv.weak_high_en      = ua_weak;
    assign multi_function_port_drv.strong_low_oe_n  = ~mf_low;
    assign multi_function_port_drv.strong_high_oe_n = ~mf_high;
    assign multi_function_port_drv.weak_high_en     = mf_weak;

    // alternate inputs come from the synchronised levels, pin stays a port bit
    assign serial_zero_receive    = mf_rdata[qbp_pkg::MF_RXD];
    assign ext_irq_zero_input     = mf_rdata[qbp_pkg::MF_IRQ0];
    assign ext_irq_one_input      = mf_rdata[qbp_pkg::MF_IRQ1];
    assign timer_zero_count_input = mf_rdata[qbp_pkg::MF_TMR0];
    assign timer_one_count_input  = mf_rdata[qbp_pkg::MF_TMR1];

    // ------------------------------------------------------------
    // access pin; synchronised, but a glitch sampled at one edge still flips one fetch
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_access_sync = {access_sync_ff[0], external_access_select};
    end

    // two flops; only the second one feeds the fetch selection
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            access_sync_ff <= qbp_pkg::SYNC_RST;
        else if (ce)
            access_sync_ff <= nxt_access_sync;
    end

    // low pin wins over the internal selection
    assign fetch_external = !access_sync_ff[1] || !int_code_sel;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_zero_drives_low;
        @(posedge clk) disable iff (!resetn)
        (ce && mf_wr && !mf_wdata[2]) |=> !multi_function_port_drv.strong_low_oe_n[2];
    endproperty
    a_zero_drives_low: assert property (p_zero_drives_low) else $error("no pull-down");

    property p_boost;
        @(posedge clk) disable iff (!resetn)
        (ce && mf_wr && mf_wdata[4] && !mf_latch[4] && !mf_ovr_en[4])
            |=> !multi_function_port_drv.strong_high_oe_n[4];
    endproperty
    a_boost: assert property (p_boost) else $error("no strong pull-up pulse");

    property p_boost_ends;
        @(posedge clk) disable iff (!resetn)
        ua_high[0] |-> (ua_weak[0] && !ua_low[0]);
    endproperty
    a_boost_ends: assert property (p_boost_ends) else $error("pull-up fights pull-down");

    property p_ua_bus;
        @(posedge clk) disable iff (!resetn)
        (ce && ext_bus_active && !ext_addr_hi[3]) |=> ua_low[3];
    endproperty
    a_ua_bus: assert property (p_ua_bus) else $error("address not driven");

    property p_wr_strobe;
        @(posedge clk) disable iff (!resetn)
        (ce && mf_alt.wr_en && !mf_alt.wr_n) |=> mf_low[qbp_pkg::MF_WR];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

    property p_access_low;
        @(posedge clk) disable iff (!resetn)
        (ce && !external_access_select) ##1 (ce && !external_access_select)
            |=> fetch_external;
    endproperty
    a_access_low: assert property (p_access_low) else $error("access pin not obeyed");

    property p_sync;
        @(posedge clk) disable iff (!resetn)
        (ce && $past(ce) && $past(ce, 2)) |-> mf_rdata[0] == $past(multi_function_port_in[0], 2);
    endproperty
    a_sync: assert property (p_sync) else $error("input read wrong");

    property p_latch_hold;
        @(posedge clk) disable iff (!resetn)
        !mf_wr |=> $stable(mf_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

    property p_low_holds;
        @(posedge clk) disable iff (!resetn)
        (!multi_function_port_drv.strong_low_oe_n[5] && !(ce && mf_wr && mf_wdata[5]))
            |=> !multi_function_port_drv.strong_low_oe_n[5];
    endproperty
    a_low_holds: assert property (p_low_holds) else $error("pull-down let go");

    property p_ua_gpio;
        @(posedge clk) disable iff (!resetn)
        (ce && ua_wr && !ext_bus_active) |=> ua_low == ~$past(ua_wdata);
    endproperty
    a_ua_gpio: assert property (p_ua_gpio) else $error("latch not on pins");

    property p_rd_strobe;
        @(posedge clk) disable iff (!resetn)
        (ce && mf_alt.rd_en && !mf_alt.rd_n) |=> mf_low[qbp_pkg::MF_RD];
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");

    property p_rxd;
        @(posedge clk) disable iff (!resetn)
        (ce && $past(ce) && $past(ce, 2))
            |-> serial_zero_receive == $past(multi_function_port_in[qbp_pkg::MF_RXD], 2);
    endproperty
    a_rxd: assert property (p_rxd) else $error("serial receive wrong");

    c_write_zero: cover property (@(posedge clk) mf_wr && mf_wdata == 8'h00);
    c_boost:      cover property (@(posedge clk) mf_high != 8'h00);
    c_bus:        cover property (@(posedge clk) ext_bus_active);
    c_ext_fetch:  cover property (@(posedge clk) fetch_external);

endmodule : qbp_port

//--- qbp_pin_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// outside circuits on one 8-bit port
// ------------------------------------------------------------
module qbp_pin_model
(
    input  wire logic           clk,
    input  qbp_pkg::qbp_drive_s drv,
    input  wire logic [7:0]     ext_low,
    output logic [7:0]          level
);
    logic tog_ff = 1'b0;

    // stand-in for a floating line, so no stale level survives
    always_ff @(posedge clk)
        tog_ff <= ~tog_ff;

    // strong low or an outside pull-down wins over any pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!drv.strong_low_oe_n[i] || ext_low[i])
                level[i] = 1'b0;
            else if (!drv.strong_high_oe_n[i] || drv.weak_high_en[i])
                level[i] = 1'b1;
            else
                level[i] = tog_ff;
        end
    end
endmodule : qbp_pin_model

//--- quasi_bidir_port_alt_func_tb.sv
`timescale 1ns/100ps
module quasi_bidir_port_alt_func_tb;
    logic clk = 0, resetn = 0, ce = 1, ua_wr = 0, mf_wr = 0, bus = 0;
    logic acc_pin = 1, isel = 1, sz, i0, i1, t0, t1, fext;
    logic [7:0] ua_wd = 0, mf_wd = 0, addr = 0, ua_l, ua_rd, mf_l, mf_rd;
    logic [7:0] ua_pin, mf_pin, ua_ext = 0, mf_ext = 0;
    qbp_pkg::qbp_drive_s ua_drv, mf_drv;
    qbp_pkg::qbp_alt_s   alt = '0;
    int failures = 0, n_checks = 0;

    always #2 clk = ~clk;

    qbp_port qbp_port_i (.clk(clk), .resetn(resetn), .ce(ce), .ua_wr(ua_wr),
        .ua_wdata(ua_wd), .ua_latch(ua_l), .ua_rdata(ua_rd), .ext_bus_active(bus),
        .ext_addr_hi(addr), .upper_address_port_in(ua_pin),
        .upper_address_port_drv(ua_drv), .mf_wr(mf_wr), .mf_wdata(mf_wd),
        .mf_latch(mf_l), .mf_rdata(mf_rd), .mf_alt(alt),
        .multi_function_port_in(mf_pin), .multi_function_port_drv(mf_drv),
        .serial_zero_receive(sz), .ext_irq_zero_input(i0), .ext_irq_one_input(i1),
        .timer_zero_count_input(t0), .timer_one_count_input(t1),
        .external_access_select(acc_pin), .int_code_sel(isel), .fetch_external(fext));
    qbp_pin_model ua_m (.clk(clk), .drv(ua_drv), .ext_low(ua_ext), .level(ua_pin));
    qbp_pin_model mf_m (.clk(clk), .drv(mf_drv), .ext_low(mf_ext), .level(mf_pin));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // inputs move just after the edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic complete_run;
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("latches", {8'h0, ua_l, mf_l}, 24'h00FFFF);
        chk("mf_drv", mf_drv, 24'hFFFFFF);
        chk("rdata", {8'h0, ua_rd, mf_rd}, 24'h00FFFF);
    endtask : t_reset

    // back-to-back writes, per-bit pull-down and boost
    task automatic t_write;
        mf_wr = 1; mf_wd = 8'h00; tick(1);
        chk("pulldown", mf_drv.strong_low_oe_n, 8'h00);
        chk("latch0", mf_l, 8'h00);
        mf_wd = 8'hFF; tick(1);
        mf_wr = 0;
        chk("release", mf_drv, {8'hFF, 8'h00, 8'hFF});
        tick(1);
        chk("boost2", mf_drv.strong_high_oe_n, 8'h00);
        tick(1);
        chk("boost_end", mf_drv.strong_high_oe_n, 8'hFF);
        mf_wr = 1; mf_wd = 8'h5A; tick(1);
        mf_wr = 0; tick(4);
        chk("bits", mf_drv.strong_low_oe_n, 8'h5A);
        mf_wr = 1; mf_wd = 8'hFF; tick(1);
        mf_wr = 0;
        chk("bit_boost", mf_drv.strong_high_oe_n, 8'h5A);
        ce = 0; mf_wr = 1; mf_wd = 8'h00; tick(1);
        ce = 1; mf_wr = 0;
        chk("frozen", mf_l, 8'hFF);
    endtask : t_write

    // outside pull-downs reach rdata and the alternate inputs
    task automatic t_input;
        mf_ext = 8'h3D; tick(3);
        chk("mf_rd", mf_rd, 8'hC2);
        chk("latch", mf_l, 8'hFF);
        chk("alt_in", {sz, i0, i1, t0, t1}, 5'h00);
        mf_ext = 8'h00; tick(3);
        chk("alt_in1", {sz, i0, i1, t0, t1}, 5'h1F);
        ua_wr = 1; ua_wd = 8'h3C; tick(1);
        ua_wr = 0; tick(3);
        chk("ua_rd", ua_rd, 8'h3C);
    endtask : t_input

    task automatic t_alt;
        alt = '{txd_en: 1, txd: 0, wr_en: 1, wr_n: 0, rd_en: 1, rd_n: 0}; tick(1);
        chk("strobes", mf_drv.strong_low_oe_n, 8'h3D);
        chk("alt_latch", mf_l, 8'hFF);
        alt = '{txd_en: 1, txd: 1, wr_en: 1, wr_n: 1, rd_en: 1, rd_n: 1}; tick(1);
        chk("strobe_hi", mf_drv, {8'hFF, 8'h3D, 8'hFF});
        alt = '0; tick(2);
    endtask : t_alt

    // address byte hides the latch while the bus runs
    task automatic t_bus;
        addr = 8'hA5; bus = 1; tick(1);
        chk("addr", ua_drv.strong_low_oe_n, 8'hA5);
        chk("ua_drv", ua_drv, {8'hA5, 8'h7E, 8'hA5});
        ua_wr = 1; ua_wd = 8'h00; tick(1);
        ua_wr = 0; tick(1);
        chk("bus_pin", ua_drv.strong_low_oe_n, 8'hA5);
        chk("bus_latch", ua_l, 8'h00);
        bus = 0; tick(1);
        chk("gpio", ua_drv.strong_low_oe_n, 8'h00);
    endtask : t_bus

    // a reset in mid-run drops the pull-downs on both ports at once
    task automatic t_mid_reset;
        mf_wr = 1;
        mf_wd = 8'h00;
        tick(1);
        mf_wr = 0;
        resetn = 0;
        tick(1);
        chk("rst_mf", mf_drv, 24'hFFFFFF);
        chk("rst_ua", ua_drv, 24'hFFFFFF);
        chk("rst_latch", {8'h00, ua_l, mf_l}, 24'h00FFFF);
        resetn = 1;
        tick(1);
        chk("rst_rd", {8'h00, ua_rd, mf_rd}, 24'h00FFFF);
    endtask : t_mid_reset

    task automatic t_access;
        for (int i = 0; i < 4; i++)
        begin
            acc_pin = i[1];
            isel = i[0];
            tick(3);
            chk("fetch_ext", fext, !i[1] || !i[0]);
        end
    endtask : t_access

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        tick(20);
        resetn = 1;
        tick(1);
        t_reset();
        t_write();
        t_input();
        t_alt();
        t_bus();
        t_mid_reset();
        t_access();
        complete_run();
    end

    initial
    begin
        #8000;
        failures++;
        complete_run();
    end
endmodule : quasi_bidir_port_alt_func_tb
